// ===== logic/boot_control_pkg.sv
package boot_control_pkg;
  typedef enum logic [1:0] {
    CFG_SRC_LOCAL_BUS = 2'b00,
    CFG_SRC_SERIAL = 2'b01,
    CFG_SRC_HARDCODED = 2'b10
  } cfg_source_t;

  typedef enum logic [1:0] {
    BOOT_MEM_DDR = 2'b00,
    BOOT_MEM_LOCAL = 2'b01,
    BOOT_MEM_PCI = 2'b10
  } boot_mem_t;

  typedef enum logic [1:0] {
    CFG_IDLE = 2'b00,
    CFG_RETRY = 2'b01,
    CFG_STALL = 2'b10,
    CFG_DONE = 2'b11
  } cfg_state_t;
endpackage

// ===== logic/boot_control_regs.svh
`ifndef BOOT_CONTROL_REGS_SVH
`define BOOT_CONTROL_REGS_SVH

// axi4-lite register byte offsets
`define OFS_FUNCTION_CONTROL 8'h00
`define OFS_ARBITER_CONFIG 8'h04
`define OFS_BOOT_STATUS 8'h08
`define OFS_BOOT_VECTOR 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_SEMAPHORE 8'h18
`define OFS_MAP_BASE 8'h1C

// function control fields
`define FUNC_CFG_ENABLE_BIT 0
// arbiter config fields
`define ARB_CORE_HOLD_OFF_BIT 0
// semaphore fields
`define SEM_CORE_READY_BIT 0
`define SEM_HOST_RELEASE_BIT 1

// interrupt status bits
`define IRQ_CORE_READY_BIT 0
`define IRQ_HOST_RELEASE_BIT 1
`define IRQ_MAP_DONE_BIT 2
`define IRQ_CORE_START_BIT 3
`define IRQ_WIDTH 4

// configuration space offset of the internal map base
`define CFG_OFS_MAP_BASE 8'h10
// inbound window onto register space, 1 Mbyte
`define MAP_WINDOW_BYTES 32'h0010_0000

// default boot vector, DDR SDRAM
`define DEFAULT_BOOT_ADDR 32'hFF80_0000

// internal map update time
`define MAP_UPDATE_MS 100
`define CLK_MHZ 125
`define MAP_UPDATE_CYCLES (`MAP_UPDATE_MS * 1000 * `CLK_MHZ)

`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ===== logic/pci_agent_boot_control.sv
`timescale 1ns/1ps
`include "boot_control_regs.svh"

// Operation
// - host config cycles accepted only once the config enable bit is set
// - while config access is locked, host config cycles get a retry
// - the core programs the internal map base itself during on-board setup
// - core signals readiness by semaphore, late enable or interrupt, then waits
// - released core boots from location chosen by boot space and rom fields
// - hardcoded reset configuration boots from 0xFF80_0000 in DDR SDRAM
// - clearing core hold-off in arbiter config starts the core
// - map base write starts a 100 ms update holding off internal writes
// - during an update, posted writes buffer until full, then the next write stalls
// - internal map base sits at config offset 0x10, written by config writes
// - map base write opens a 1 Mbyte inbound window on register space
// - after reset config access is locked unless reset source enables it
// - hardcoded reset config disables core and sets config enable bit
module pci_agent_boot_control
  import boot_control_pkg::*;
#(
  parameter int unsigned UPDATE_CYCLES = `MAP_UPDATE_CYCLES,
  parameter int unsigned POST_DEPTH = 4,
  parameter logic [31:0] LOCAL_BOOT_ADDR = 32'hFFF0_0000,
  parameter logic [31:0] PCI_BOOT_ADDR = 32'h0000_0100
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [1:0] cfg_source,
  input wire logic cfg_core_hold_off,
  input wire logic cfg_access_enable,
  input wire logic [1:0] boot_memory_space,
  input wire logic boot_rom_location,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_offset,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic cfg_retry,
  output logic [31:0] cfg_rdata,
  input wire logic [31:0] post_addr,
  input wire logic post_valid,
  output logic post_ready,
  output logic win_hit,
  output logic core_run,
  output logic [31:0] boot_vector,
  output logic [1:0] boot_device,
  output logic host_intr,
  output logic irq,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  localparam int unsigned PW = $clog2(POST_DEPTH + 1);
  logic cfg_enable_reg;
  logic core_hold_off_reg;
  logic [31:0] map_base_reg;
  logic [31:0] boot_vector_reg;
  logic [1:0] boot_device_reg;
  logic strap_taken_reg;
  logic [1:0] sem_reg;
  logic [`IRQ_WIDTH-1:0] irq_status_reg;
  logic [`IRQ_WIDTH-1:0] irq_mask_reg;
  logic [`IRQ_WIDTH-1:0] irq_event;
  logic [PW-1:0] post_count_reg;
  cfg_state_t cfg_state_reg;
  logic update_start;
  logic update_busy;
  logic busy_d_reg;
  logic core_run_d_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic wr_go;
  logic map_hit;
  logic [31:0] cfg_read_value;
  update_timer #(
    .CYCLES(UPDATE_CYCLES)
  ) u_update_timer (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(update_start),
    .busy(update_busy)
  );
  // straps are sampled once, one edge after reset release
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      strap_taken_reg <= 1'b0;
    end else begin
      strap_taken_reg <= 1'b1;
    end
  end
  wire logic strap_load = !strap_taken_reg;
  wire logic hardcoded = (cfg_source == CFG_SRC_HARDCODED);
  wire logic aw_take = awvalid && awready;
  wire logic w_take = wvalid && wready;
  assign awready = !aw_full_reg && !bvalid;
  assign wready = !w_full_reg && !bvalid;
  wire logic [7:0] wr_addr = aw_full_reg ? aw_addr_reg : awaddr;
  wire logic [31:0] wr_data = w_full_reg ? w_data_reg : wdata;
  wire logic [3:0] wr_strb = w_full_reg ? w_strb_reg : wstrb;
  assign wr_go = (aw_full_reg || aw_take) && (w_full_reg || w_take);
  wire logic wr_lane0 = wr_go && wr_strb[0];
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (wr_go) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid <= 1'b0;
      bresp <= `AXI_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= (wr_addr[7:5] == 3'h0 && wr_addr[1:0] == 2'h0) ? `AXI_OKAY : `AXI_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
  // locked out of reset unless the reset source enables it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_enable_reg <= 1'b0;
    end else if (strap_load) begin
      cfg_enable_reg <= hardcoded || cfg_access_enable;
    end else if (wr_lane0 && wr_addr == `OFS_FUNCTION_CONTROL) begin
      cfg_enable_reg <= wr_data[`FUNC_CFG_ENABLE_BIT];
    end
  end
  // core stays held until the straps are in, so it never runs on a stale vector
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      core_hold_off_reg <= 1'b1;
    end else if (strap_load) begin
      core_hold_off_reg <= hardcoded || cfg_core_hold_off;
    end else if (wr_lane0 && wr_addr == `OFS_ARBITER_CONFIG) begin
      core_hold_off_reg <= wr_data[`ARB_CORE_HOLD_OFF_BIT];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      boot_vector_reg <= `DEFAULT_BOOT_ADDR;
      boot_device_reg <= BOOT_MEM_DDR;
    end else if (strap_load) begin
      if (hardcoded) begin
        boot_vector_reg <= `DEFAULT_BOOT_ADDR;
        boot_device_reg <= BOOT_MEM_DDR;
      end else begin
        boot_device_reg <= boot_memory_space;
        unique case (boot_memory_space)
          BOOT_MEM_LOCAL: boot_vector_reg <= LOCAL_BOOT_ADDR;
          BOOT_MEM_PCI: boot_vector_reg <= PCI_BOOT_ADDR;
          default: boot_vector_reg <= boot_rom_location ? `DEFAULT_BOOT_ADDR
                                                       : 32'h0000_0100;
        endcase
      end
    end
  end
  // map base written by the core over axi or the host over config cycles
  wire logic core_map_wr = wr_lane0 && wr_addr == `OFS_MAP_BASE;
  wire logic host_map_wr = (cfg_state_reg == CFG_IDLE) && cfg_req && cfg_enable_reg
                           && cfg_write && cfg_offset == `CFG_OFS_MAP_BASE;
  assign update_start = core_map_wr || host_map_wr;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      map_base_reg <= 32'h0000_0000;
    end else if (core_map_wr) begin
      map_base_reg <= {wr_data[31:20], 20'h0_0000};
    end else if (host_map_wr) begin
      map_base_reg <= {cfg_wdata[31:20], 20'h0_0000};
    end
  end
  assign cfg_read_value = (cfg_offset == `CFG_OFS_MAP_BASE) ? map_base_reg : 32'h0000_0000;
  wire logic map_read = !cfg_write && cfg_offset == `CFG_OFS_MAP_BASE;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_state_reg <= CFG_IDLE;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      unique case (cfg_state_reg)
        CFG_IDLE: begin
          if (cfg_req) begin
            if (!cfg_enable_reg) begin
              cfg_state_reg <= CFG_RETRY;
            end else if (map_read && update_busy) begin
              cfg_state_reg <= CFG_STALL;
            end else begin
              cfg_state_reg <= CFG_DONE;
              cfg_rdata <= cfg_read_value;
            end
          end
        end
        CFG_STALL: begin
          if (!update_busy) begin
            cfg_state_reg <= CFG_DONE;
            cfg_rdata <= map_base_reg;
          end
        end
        CFG_RETRY, CFG_DONE: cfg_state_reg <= CFG_IDLE;
      endcase
    end
  end
  assign cfg_ack = (cfg_state_reg == CFG_DONE);
  assign cfg_retry = (cfg_state_reg == CFG_RETRY);
  // posted writes fill the buffer during the update, then the source stalls
  assign win_hit = post_addr[31:20] == map_base_reg[31:20];
  assign post_ready = !update_busy || (post_count_reg != PW'(POST_DEPTH));
  assign map_hit = post_valid && post_ready;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      post_count_reg <= '0;
    end else if (!update_busy) begin
      post_count_reg <= '0;
    end else if (map_hit) begin
      post_count_reg <= post_count_reg + PW'(1);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sem_reg <= 2'b00;
    end else if (wr_lane0 && wr_addr == `OFS_SEMAPHORE) begin
      sem_reg <= wr_data[1:0];
    end
  end
  assign host_intr = sem_reg[`SEM_CORE_READY_BIT];
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_d_reg <= 1'b0;
      core_run_d_reg <= 1'b0;
    end else begin
      busy_d_reg <= update_busy;
      core_run_d_reg <= core_run;
    end
  end
  assign core_run = strap_taken_reg && !core_hold_off_reg;
  assign boot_vector = boot_vector_reg;
  assign boot_device = boot_device_reg;
  always_comb begin
    irq_event = '0;
    irq_event[`IRQ_CORE_READY_BIT] = wr_go && wr_strb[0] && wr_addr == `OFS_SEMAPHORE
                                     && wr_data[`SEM_CORE_READY_BIT];
    irq_event[`IRQ_HOST_RELEASE_BIT] = wr_go && wr_strb[0] && wr_addr == `OFS_SEMAPHORE
                                       && wr_data[`SEM_HOST_RELEASE_BIT];
    irq_event[`IRQ_MAP_DONE_BIT] = busy_d_reg && !update_busy;
    irq_event[`IRQ_CORE_START_BIT] = core_run && !core_run_d_reg;
  end
  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~((wr_lane0 && wr_addr == `OFS_IRQ_STATUS)
                        ? wr_data[`IRQ_WIDTH-1:0] : '0)) | irq_event;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask_reg <= '0;
    end else if (wr_lane0 && wr_addr == `OFS_IRQ_MASK) begin
      irq_mask_reg <= wr_data[`IRQ_WIDTH-1:0];
    end
  end
  assign irq = |(irq_status_reg & irq_mask_reg);
  assign arready = !rvalid;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `AXI_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `AXI_OKAY;
      unique case (araddr)
        `OFS_FUNCTION_CONTROL: rdata <= {31'h0, cfg_enable_reg};
        `OFS_ARBITER_CONFIG: rdata <= {31'h0, core_hold_off_reg};
        `OFS_BOOT_STATUS: rdata <= {26'h0, boot_device_reg, post_count_reg == PW'(POST_DEPTH),
                                    update_busy, core_run, cfg_enable_reg};
        `OFS_BOOT_VECTOR: rdata <= boot_vector_reg;
        `OFS_IRQ_STATUS: rdata <= {28'h0, irq_status_reg};
        `OFS_IRQ_MASK: rdata <= {28'h0, irq_mask_reg};
        `OFS_SEMAPHORE: rdata <= {30'h0, sem_reg};
        `OFS_MAP_BASE: rdata <= map_base_reg;
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `AXI_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
  locked_retry_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_state_reg == CFG_IDLE && cfg_req && !cfg_enable_reg) |=> cfg_retry && !cfg_ack)
    else $error("locked config cycle not retried");
  enabled_ack_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg_ack |-> $past(cfg_enable_reg, 1) || $past(cfg_state_reg, 1) == CFG_STALL)
    else $error("config cycle acked while locked");
  hold_run_a: assert property (@(posedge mclk) disable iff (!reset_n)
    core_run |-> !core_hold_off_reg && strap_taken_reg)
    else $error("core runs while held off");
  map_busy_a: assert property (@(posedge mclk) disable iff (!reset_n)
    update_start |=> update_busy [*8])
    else $error("map update ended too early");
  post_stall_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (update_busy && post_count_reg == PW'(POST_DEPTH)) |-> !post_ready)
    else $error("posted write accepted past buffer depth");
  read_barrier_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_state_reg == CFG_STALL && update_busy) |=> !cfg_ack)
    else $error("map read completed during update");
  hard_boot_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (strap_load && hardcoded) |=> boot_vector == `DEFAULT_BOOT_ADDR
      && cfg_enable_reg && !core_run)
    else $error("hardcoded reset config misapplied");
  lock_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (strap_load && !hardcoded && !cfg_access_enable) |=> !cfg_enable_reg)
    else $error("config access open out of reset");
  map_offset_a: assert property (@(posedge mclk) disable iff (!reset_n)
    host_map_wr |=> map_base_reg[31:20] == $past(cfg_wdata[31:20], 1)
      && map_base_reg[19:0] == 20'h0)
    else $error("map base not written at its offset");
endmodule

// ===== logic/update_timer.sv
`timescale 1ns/1ps
`include "boot_control_regs.svh"

// counts a fixed busy period from a one-cycle start pulse
module update_timer #(
  parameter int unsigned CYCLES = 100
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  output logic busy
);
  localparam int unsigned CW = $clog2(CYCLES + 1);
  logic [CW-1:0] count_reg;

  // a restart during the busy period lengthens it to a full period
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else if (start) begin
      count_reg <= CW'(CYCLES);
    end else if (count_reg != '0) begin
      count_reg <= count_reg - CW'(1);
    end
  end

  assign busy = (count_reg != '0);
endmodule

// ===== test/pci_host_model.sv
`timescale 1ns/1ps
// host side: configuration cycles and posted memory writes
module pci_host_model (
  input wire logic mclk,
  input wire logic cfg_ack,
  input wire logic cfg_retry,
  input wire logic [31:0] cfg_rdata,
  input wire logic post_ready,
  input wire logic win_hit,
  output logic cfg_req,
  output logic cfg_write,
  output logic [7:0] cfg_offset,
  output logic [31:0] cfg_wdata,
  output logic [31:0] post_addr,
  output logic post_valid
);
  initial begin
    cfg_req = 1'h0;
    cfg_write = 1'h0;
    cfg_offset = 8'h00;
    cfg_wdata = 32'h0;
    post_addr = 32'h0;
    post_valid = 1'h0;
  end

  // one attempt only; a retry goes back to the caller, who decides to repeat
  task automatic cfg_cycle(input logic wr, input logic [7:0] off, input logic [31:0] wd,
      output logic [31:0] rd, output logic retried, output int waited);
    waited = 0;
    cfg_req <= 1'h1;
    cfg_write <= wr;
    cfg_offset <= off;
    cfg_wdata <= wd;
    do begin
      @(posedge mclk);
      waited++;
    end while (cfg_ack !== 1'h1 && cfg_retry !== 1'h1);
    rd = cfg_rdata;
    retried = cfg_retry;
    cfg_req <= 1'h0;
    // released payload flips so a stale value is never mistaken for a live one
    cfg_offset <= ~off;
    cfg_wdata <= ~wd;
    @(posedge mclk);
  endtask

  // software copy into adapter memory, one word per call
  task automatic post_write(input logic [31:0] a, output logic hit, output int waited);
    waited = 0;
    post_addr <= a;
    post_valid <= 1'h1;
    do begin
      @(posedge mclk);
      waited++;
      hit = win_hit;
    end while (post_ready !== 1'h1);
    post_valid <= 1'h0;
    post_addr <= ~a;
    @(posedge mclk);
  endtask
endmodule

// ===== test/test_pci_agent_boot_control.sv
`timescale 1ns/1ps
`include "boot_control_regs.svh"
module test_pci_agent_boot_control
  import boot_control_pkg::*;
;
  localparam logic [31:0] LOC_ADDR = 32'hFFF0_0000;
  localparam logic [31:0] PCI_ADDR = 32'h0000_0100;
  logic mclk, reset_n, cfg_core_hold_off, cfg_access_enable, boot_rom_location;
  logic [1:0] cfg_source, boot_memory_space, boot_device, bresp, rresp;
  logic cfg_req, cfg_write, cfg_ack, cfg_retry, post_valid, post_ready, win_hit;
  logic core_run, host_intr, irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] cfg_offset, awaddr, araddr;
  logic [31:0] cfg_wdata, cfg_rdata, post_addr, boot_vector, wdata, rdata;
  logic [3:0] wstrb;
  int num_errors, checks, cycles;
  logic [1:0] space_tab [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
  logic rom_tab [4] = '{1'h0, 1'h0, 1'h1, 1'h0};
  logic [31:0] vec_tab [4] = '{LOC_ADDR, PCI_ADDR, 32'hFF80_0000, 32'h0000_0100};
  logic [31:0] post_tab [5] = '{32'hA000_0000, 32'hA00F_FFFC, 32'hA010_0000,
                                32'h9FFF_FFFC, 32'hA000_0010};
  logic hit_tab [5] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1};

  pci_agent_boot_control #(.UPDATE_CYCLES(20), .POST_DEPTH(4), .LOCAL_BOOT_ADDR(LOC_ADDR),
      .PCI_BOOT_ADDR(PCI_ADDR)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .cfg_source(cfg_source),
    .cfg_core_hold_off(cfg_core_hold_off), .cfg_access_enable(cfg_access_enable),
    .boot_memory_space(boot_memory_space), .boot_rom_location(boot_rom_location),
    .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_offset(cfg_offset),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_retry(cfg_retry), .cfg_rdata(cfg_rdata),
    .post_addr(post_addr), .post_valid(post_valid), .post_ready(post_ready),
    .win_hit(win_hit), .core_run(core_run), .boot_vector(boot_vector),
    .boot_device(boot_device), .host_intr(host_intr), .irq(irq),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  pci_host_model u_host (
    .mclk(mclk), .cfg_ack(cfg_ack), .cfg_retry(cfg_retry), .cfg_rdata(cfg_rdata),
    .post_ready(post_ready), .win_hit(win_hit), .cfg_req(cfg_req), .cfg_write(cfg_write),
    .cfg_offset(cfg_offset), .cfg_wdata(cfg_wdata), .post_addr(post_addr),
    .post_valid(post_valid));

  always #4 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // guards against a design that never answers
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic do_reset(input logic [1:0] src, input logic hold, input logic acc,
      input logic [1:0] space, input logic rom);
    cfg_source <= src;
    cfg_core_hold_off <= hold;
    cfg_access_enable <= acc;
    boot_memory_space <= space;
    boot_rom_location <= rom;
    reset_n <= 1'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (2) @(posedge mclk);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic rt, h;
    int w;
    mclk = 1'h0;
    reset_n = 1'h0;
    {cfg_source, cfg_core_hold_off, cfg_access_enable} = 4'h0;
    {boot_memory_space, boot_rom_location} = 3'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    for (int i = 0; i < 4; i++) begin
      do_reset(CFG_SRC_SERIAL, 1'h1, 1'h1, space_tab[i], rom_tab[i]);
      check(boot_vector, vec_tab[i]);
      check({30'h0, boot_device}, {30'h0, space_tab[i]});
      axi_read(`OFS_BOOT_VECTOR, d, r);
      check(d, vec_tab[i]);
      check({31'h0, core_run}, 32'h0);
    end
    // hardcoded source overrides the other straps
    do_reset(CFG_SRC_HARDCODED, 1'h0, 1'h0, 2'h1, 1'h0);
    check({31'h0, core_run}, 32'h0);
    axi_read(`OFS_BOOT_STATUS, d, r);
    check({31'h0, d[0]}, 32'h1);
    check(boot_vector, 32'hFF80_0000);
    check({30'h0, boot_device}, 32'h0);
    u_host.cfg_cycle(1'h1, `CFG_OFS_MAP_BASE, 32'hA005_5000, d, rt, w);
    check({31'h0, rt}, 32'h0);
    u_host.cfg_cycle(1'h0, `CFG_OFS_MAP_BASE, 32'h0, d, rt, w);
    check(d, 32'hA000_0000);
    check({31'h0, w > 10}, 32'h1);
    u_host.cfg_cycle(1'h1, `CFG_OFS_MAP_BASE, 32'hA000_0000, d, rt, w);
    for (int i = 0; i < 5; i++) begin
      u_host.post_write(post_tab[i], h, w);
      check({31'h0, h}, {31'h0, hit_tab[i]});
      check({31'h0, w > 1}, {31'h0, i == 4});
    end
    axi_read(`OFS_BOOT_STATUS, d, r);
    check({31'h0, d[2]}, 32'h0);
    axi_read(`OFS_IRQ_STATUS, d, r);
    check({31'h0, d[2]}, 32'h1);
    axi_write(`OFS_ARBITER_CONFIG, 32'h0, r);
    check({31'h0, core_run}, 32'h1);
    check(boot_vector, 32'hFF80_0000);
    axi_write(8'h20, 32'h1, r);
    check({30'h0, r}, {30'h0, `AXI_SLVERR});
    axi_read(8'h24, d, r);
    check({30'h0, r}, {30'h0, `AXI_SLVERR});
    // on-board case: core runs, host locked out
    do_reset(CFG_SRC_LOCAL_BUS, 1'h0, 1'h0, 2'h0, 1'h1);
    axi_read(`OFS_BOOT_STATUS, d, r);
    check({31'h0, d[0]}, 32'h0);
    u_host.cfg_cycle(1'h0, `CFG_OFS_MAP_BASE, 32'h0, d, rt, w);
    check({31'h0, rt}, 32'h1);
    axi_write(`OFS_FUNCTION_CONTROL, 32'h1, r);
    u_host.cfg_cycle(1'h0, `CFG_OFS_MAP_BASE, 32'h0, d, rt, w);
    check({31'h0, rt}, 32'h0);
    axi_write(`OFS_MAP_BASE, 32'hA00A_BCDE, r);
    axi_read(`OFS_BOOT_STATUS, d, r);
    check({31'h0, d[2]}, 32'h1);
    axi_read(`OFS_MAP_BASE, d, r);
    check(d, 32'hA000_0000);
    u_host.cfg_cycle(1'h0, `CFG_OFS_MAP_BASE, 32'h0, d, rt, w);
    check(d, 32'hA000_0000);
    axi_write(`OFS_IRQ_STATUS, 32'hF, r);
    axi_write(`OFS_SEMAPHORE, 32'h1, r);
    check({31'h0, host_intr}, 32'h1);
    axi_read(`OFS_IRQ_STATUS, d, r);
    check(d, 32'h1);
    axi_write(`OFS_IRQ_MASK, 32'h0, r);
    check({31'h0, irq}, 32'h0);
    axi_write(`OFS_IRQ_MASK, 32'hF, r);
    check({31'h0, irq}, 32'h1);
    axi_write(`OFS_IRQ_STATUS, 32'h1, r);
    check({31'h0, irq}, 32'h0);
    axi_write(`OFS_SEMAPHORE, 32'h2, r);
    check({31'h0, host_intr}, 32'h0);
    axi_read(`OFS_IRQ_STATUS, d, r);
    check(d & 32'h2, 32'h2);
    complete_run();
  end
endmodule
